/* hdl/morf_regs.sv */
`timescale 1ns/1ns
module morf_regs (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // core operation port
    input wire logic OP_VALID,
    input wire logic [3:0] OP_CODE,
    input wire logic [9:0] OP_IMM,
    input wire logic [7:0] OP_ACC,
    // events from same-clock logic
    input wire logic WDT_TIMEOUT,
    input wire logic EXT_RESET,
    input wire logic CNT1_DONE,
    input wire logic CNT2_DONE,
    // asynchronous pins
    input wire logic TCC_SLOW_PIN,
    input wire logic [3:0] P7_INT_PIN,
    input wire logic [7:0] P9_PIN,
    // core controls
    output logic [13:0] PC_ADDR,
    output logic CORE_RESTART,
    output logic CORE_STOPPED,
    output logic IO_PAGE,
    output logic FAST_CLK_ON,
    output logic WATCHDOG_ON,
    output logic [2:0] DISPLAY_MODE
);

// ----------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------
logic [12:0] s1_r, s2_r, s3_r, stab_r, stab_nxt;
logic [12:0] fall, rise;

always_comb
begin
    for (int i = 0; i < morf_pkg::SYNC_W; i++)
    begin
        stab_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stab_r[i];
    end
    fall = stab_r & ~stab_nxt;
    rise = ~stab_r & stab_nxt;
end

always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        s1_r <= 13'h1FFF;
        s2_r <= 13'h1FFF;
        s3_r <= 13'h1FFF;
        stab_r <= 13'h1FFF;
    end
    else if (CE)
    begin
        s1_r <= {P9_PIN, P7_INT_PIN, TCC_SLOW_PIN};
        s2_r <= s1_r;
        s3_r <= s2_r;
        stab_r <= stab_nxt;
    end
end

// ----------------------------------------------------------
// state
// ----------------------------------------------------------
morf_pkg::morf_state_e state_r, state_nxt;
logic [13:0] pc_r, pc_nxt;
logic [13:0] stk_r [morf_pkg::STACK_DEPTH];
logic [13:0] stk_nxt [morf_pkg::STACK_DEPTH];
logic [2:0] sp_r, sp_nxt;
logic [7:0] tcc_r, tcc_nxt, status_r, status_nxt;
logic [7:0] bank_r, bank_nxt, page_r, page_nxt;
logic [7:0] p6_r, p6_nxt, p7_r, p7_nxt, p8_r, p8_nxt;
logic [7:0] p9_r, p9_nxt, mode_r, mode_nxt;
logic [7:0] raddr_r, raddr_nxt, rdata_r, rdata_nxt;
logic [7:0] disp_r, disp_nxt, intf_r, intf_nxt;
logic [7:0] tctl_r, tctl_nxt;
logic restart_r, restart_nxt, stopped_r, stopped_nxt;
logic [31:0] prdata_r, prdata_nxt;
logic pready_r, pready_nxt, perr_r, perr_nxt;
logic [7:0] gp_r [256];
logic gp_we;
logic [7:0] wd, rd, p9_fall, set;
logic wr, hit, tick, p9_wake, p7_wake, run_op;
logic [7:0] sum;

// far address: page bits over a ten-bit low part
function automatic logic [13:0] far_addr(input logic [7:0] pg,
                                         input logic [9:0] lo);
    far_addr = {pg[3:0], lo};
endfunction

// ----------------------------------------------------------
// next-state logic
// ----------------------------------------------------------
always_comb
begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    stk_nxt = stk_r;
    sp_nxt = sp_r;
    tcc_nxt = tcc_r;
    status_nxt = status_r;
    bank_nxt = bank_r;
    page_nxt = page_r;
    p6_nxt = p6_r;
    p7_nxt = p7_r;
    p8_nxt = p8_r;
    p9_nxt = p9_r;
    mode_nxt = mode_r;
    raddr_nxt = raddr_r;
    rdata_nxt = rdata_r;
    disp_nxt = disp_r;
    intf_nxt = intf_r;
    tctl_nxt = tctl_r;
    restart_nxt = 1'b0;
    wd = PWDATA[7:0];
    wr = PSEL && PENABLE && pready_r && PWRITE;
    gp_we = 1'b0;
    sum = pc_r[7:0] + OP_ACC;
    // timer source: slow pin edge or every enabled cycle
    tick = tctl_r[0] ? rise[0] : 1'b1;
    if (tick)
    begin
        tcc_nxt = tcc_r + 8'h01;
    end
    p9_fall = fall[12:5];
    p9_wake = |(p9_fall & {{4{disp_r[5]}}, {4{disp_r[4]}}});
    p7_wake = |fall[4:1];
    // falling pin edges only; counter units pulse their flags
    set = {fall[4], 1'b0, CNT2_DONE, CNT1_DONE, fall[3:1],
           tick && (tcc_r == 8'hFF)};
    run_op = (state_r == morf_pkg::ST_RUN) && OP_VALID;
    if (run_op)
    begin
        pc_nxt = pc_r + 14'h0001;
        case (OP_CODE)
            morf_pkg::DIRECT_JUMP_OP:
                pc_nxt = far_addr(page_r, OP_IMM);
            morf_pkg::CALL_OP:
            begin
                stk_nxt[sp_r] = pc_r + 14'h0001;
                sp_nxt = sp_r + 3'd1;
                pc_nxt = far_addr(page_r, OP_IMM);
            end
            morf_pkg::SUBROUTINE_RETURN_OP:
            begin
                sp_nxt = sp_r - 3'd1;
                pc_nxt = stk_r[sp_r - 3'd1];
            end
            morf_pkg::ACC_MOVE_PC_OP:
                pc_nxt = far_addr(page_r, {2'b00, OP_ACC});
            morf_pkg::ACC_ADD_PC_OP:
                pc_nxt = far_addr(page_r, {2'b00, sum});
            morf_pkg::TABLE_OFFSET_ADD:
                pc_nxt = far_addr(page_r, {pc_r[9:8], sum});
            morf_pkg::ENTER_LOW_POWER_OP:
            begin
                status_nxt[morf_pkg::ST_P_BIT] = 1'b0;
                status_nxt[morf_pkg::ST_T_BIT] = 1'b1;
                state_nxt = mode_r[7] ? morf_pkg::ST_IDLE
                                      : morf_pkg::ST_SLEEP;
            end
            morf_pkg::WATCHDOG_CLEAR_OP:
            begin
                status_nxt[morf_pkg::ST_P_BIT] = 1'b1;
                status_nxt[morf_pkg::ST_T_BIT] = 1'b1;
            end
            default:
                pc_nxt = pc_r + 14'h0001;
        endcase
    end
    // wake and restart handling
    case (state_r)
        morf_pkg::ST_SLEEP:
            if (WDT_TIMEOUT || p9_wake)
            begin
                state_nxt = morf_pkg::ST_RUN;
                pc_nxt = morf_pkg::PC_RST;
                restart_nxt = 1'b1;
            end
        morf_pkg::ST_IDLE:
            if (tick || WDT_TIMEOUT || p9_wake || p7_wake)
            begin
                state_nxt = morf_pkg::ST_RUN;
            end
        morf_pkg::ST_RUN:
            if (WDT_TIMEOUT)
            begin
                pc_nxt = morf_pkg::PC_RST;
                restart_nxt = 1'b1;
            end
        default:
            state_nxt = morf_pkg::ST_RUN;
    endcase
    // cause pair: watchdog clears T, P keeps its sleep/awake value
    if (WDT_TIMEOUT)
    begin
        status_nxt[morf_pkg::ST_T_BIT] = 1'b0;
    end
    if (EXT_RESET)
    begin
        state_nxt = morf_pkg::ST_RUN;
        pc_nxt = morf_pkg::PC_RST;
        restart_nxt = 1'b1;
        status_nxt[morf_pkg::ST_T_BIT] = 1'b1;
    end
    stopped_nxt = state_nxt != morf_pkg::ST_RUN;
    // software writes
    if (wr)
    begin
        case (PADDR)
            morf_pkg::OFS_INDIRECT: gp_we = 1'b1;
            morf_pkg::OFS_TIMER: tcc_nxt = wd;
            morf_pkg::OFS_STATUS:
                status_nxt = (status_nxt & ~morf_pkg::ST_SW_MASK)
                           | (wd & morf_pkg::ST_SW_MASK);
            morf_pkg::OFS_BANK: bank_nxt = wd;
            morf_pkg::OFS_PAGE: page_nxt = wd;
            morf_pkg::OFS_PORT6: p6_nxt = wd & morf_pkg::PORT6_MASK;
            morf_pkg::OFS_PORT7: p7_nxt = wd;
            morf_pkg::OFS_PORT8: p8_nxt = wd;
            morf_pkg::OFS_PORT9: p9_nxt = wd;
            morf_pkg::OFS_MODE:
                mode_nxt = (wd & morf_pkg::MODE_SW_MASK)
                         | morf_pkg::MODE_FIXED;
            morf_pkg::OFS_RAM_ADDR: raddr_nxt = wd;
            morf_pkg::OFS_RAM_DATA: rdata_nxt = wd;
            morf_pkg::OFS_DISP:
                disp_nxt = wd & morf_pkg::DISP_SW_MASK;
            morf_pkg::OFS_INTSTAT:
                intf_nxt = intf_r & wd;
            morf_pkg::OFS_TIMER_CTL: tctl_nxt = {7'h00, wd[0]};
            default: tctl_nxt = tctl_r;
        endcase
    end
    // a flag raised in the clearing cycle survives
    intf_nxt = (intf_nxt | set) & morf_pkg::INT_MASK;
    // read path, sampled in the setup cycle
    hit = 1'b1;
    case (PADDR)
        morf_pkg::OFS_INDIRECT: rd = gp_r[bank_r];
        morf_pkg::OFS_TIMER: rd = tcc_r;
        morf_pkg::OFS_PC_LOW: rd = pc_r[7:0];
        morf_pkg::OFS_STATUS: rd = status_r & 8'h5F;
        morf_pkg::OFS_BANK: rd = bank_r;
        morf_pkg::OFS_PAGE: rd = page_r;
        morf_pkg::OFS_PORT6: rd = p6_r;
        morf_pkg::OFS_PORT7: rd = p7_r;
        morf_pkg::OFS_PORT8: rd = p8_r;
        morf_pkg::OFS_PORT9: rd = p9_r;
        morf_pkg::OFS_MODE: rd = mode_r;
        morf_pkg::OFS_RSVD: rd = morf_pkg::RSVD_VALUE;
        morf_pkg::OFS_RAM_ADDR: rd = raddr_r;
        morf_pkg::OFS_RAM_DATA: rd = rdata_r;
        morf_pkg::OFS_DISP: rd = disp_r;
        morf_pkg::OFS_INTSTAT: rd = intf_r;
        morf_pkg::OFS_TIMER_CTL: rd = tctl_r;
        default:
        begin
            rd = 8'h00;
            hit = 1'b0;
        end
    endcase
    // one wait-free access phase: ready the cycle after setup
    pready_nxt = PSEL && !PENABLE;
    prdata_nxt = pready_nxt ? {24'h00_0000, rd} : 32'h0000_0000;
    perr_nxt = pready_nxt && !hit;
end

// ----------------------------------------------------------
// registers
// ----------------------------------------------------------
always_ff @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        state_r <= morf_pkg::ST_RUN;
        pc_r <= morf_pkg::PC_RST;
        for (int i = 0; i < morf_pkg::STACK_DEPTH; i++)
        begin
            stk_r[i] <= morf_pkg::PC_RST;
        end
        sp_r <= 3'd0;
        tcc_r <= morf_pkg::ZERO_RST;
        status_r <= morf_pkg::STATUS_RST;
        bank_r <= morf_pkg::ZERO_RST;
        page_r <= morf_pkg::ZERO_RST;
        p6_r <= morf_pkg::ZERO_RST;
        p7_r <= morf_pkg::ZERO_RST;
        p8_r <= morf_pkg::ZERO_RST;
        p9_r <= morf_pkg::ZERO_RST;
        mode_r <= morf_pkg::MODE_FIXED;
        raddr_r <= morf_pkg::ZERO_RST;
        rdata_r <= morf_pkg::ZERO_RST;
        disp_r <= morf_pkg::ZERO_RST;
        intf_r <= morf_pkg::ZERO_RST;
        tctl_r <= morf_pkg::ZERO_RST;
        restart_r <= 1'b0;
        stopped_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
        pready_r <= 1'b0;
        perr_r <= 1'b0;
    end
    else if (CE)
    begin
        state_r <= state_nxt;
        pc_r <= pc_nxt;
        stk_r <= stk_nxt;
        sp_r <= sp_nxt;
        tcc_r <= tcc_nxt;
        status_r <= status_nxt;
        bank_r <= bank_nxt;
        page_r <= page_nxt;
        p6_r <= p6_nxt;
        p7_r <= p7_nxt;
        p8_r <= p8_nxt;
        p9_r <= p9_nxt;
        mode_r <= mode_nxt;
        raddr_r <= raddr_nxt;
        rdata_r <= rdata_nxt;
        disp_r <= disp_nxt;
        intf_r <= intf_nxt;
        tctl_r <= tctl_nxt;
        restart_r <= restart_nxt;
        stopped_r <= stopped_nxt;
        prdata_r <= prdata_nxt;
        pready_r <= pready_nxt;
        perr_r <= perr_nxt;
    end
end

// data locations reached only through the pointer; no reset
always_ff @(posedge CLK)
begin
    if (CE && gp_we)
    begin
        gp_r[bank_r] <= wd;
    end
end

assign PRDATA = prdata_r;
assign PREADY = pready_r;
assign PSLVERR = perr_r;
assign PC_ADDR = pc_r;
assign CORE_RESTART = restart_r;
assign CORE_STOPPED = stopped_r;
assign IO_PAGE = status_r[morf_pkg::ST_PAGE_BIT];
assign FAST_CLK_ON = mode_r[6];
assign WATCHDOG_ON = disp_r[6];
assign DISPLAY_MODE = disp_r[2:0];

// ----------------------------------------------------------
// checks
// ----------------------------------------------------------
default clocking @(posedge CLK); endclocking
default disable iff (!RSTN);

sequence quiet_op(logic [3:0] c);
    CE && run_op && OP_CODE == c && !WDT_TIMEOUT && !EXT_RESET;
endsequence

jump_target_a: assert property (
    quiet_op(morf_pkg::DIRECT_JUMP_OP) |=>
    pc_r == {$past(page_r[3:0]), $past(OP_IMM)})
    else $error("jump target wrong");
call_push_a: assert property (
    quiet_op(morf_pkg::CALL_OP) |=>
    stk_r[$past(sp_r)] == $past(pc_r) + 14'h0001
    && sp_r == $past(sp_r) + 3'd1)
    else $error("call did not push");
return_pop_a: assert property (
    quiet_op(morf_pkg::SUBROUTINE_RETURN_OP) |=>
    pc_r == $past(stk_r[sp_r - 3'd1]))
    else $error("return did not pop");
acc_move_a: assert property (
    quiet_op(morf_pkg::ACC_MOVE_PC_OP) |=>
    pc_r[9:8] == 2'b00 && pc_r[7:0] == $past(OP_ACC))
    else $error("accumulator move wrong");
table_keep_a: assert property (
    quiet_op(morf_pkg::TABLE_OFFSET_ADD) |=>
    pc_r[9:8] == $past(pc_r[9:8]))
    else $error("table add changed bits");
low_power_a: assert property (
    quiet_op(morf_pkg::ENTER_LOW_POWER_OP) |=>
    !status_r[3] && status_r[4] && CORE_STOPPED)
    else $error("low power entry wrong");
wdt_timeout_a: assert property (
    CE && WDT_TIMEOUT && !EXT_RESET |=> !status_r[4])
    else $error("time-out bit not cleared");
sleep_wake_a: assert property (
    CE && state_r == morf_pkg::ST_SLEEP && WDT_TIMEOUT
    && !EXT_RESET |=> pc_r == 14'h0000 && CORE_RESTART
    && !CORE_STOPPED)
    else $error("sleep wake not restarted");
int_flag_a: assert property (
    CE && fall[1] |=> intf_r[1] && !intf_r[6])
    else $error("pin flag not raised");
apb_ready_a: assert property (
    CE && PSEL && !PENABLE |=> PREADY ##1 !PREADY || PENABLE == 1'b0)
    else $error("ready timing wrong");

endmodule

/* hdl/morf_pkg.sv */
// Overview of operation
// - pointer reads/writes location named by bank select
// - timer counts slow pin or cycle clock
// - jump loads low ten counter bits
// - call pushes counter plus one, loads target
// - return reloads counter from stack top unless a watchdog time-out or reset comes in the same cycle
// - accumulator move clears counter bits nine, ten
// - accumulator add clears counter bits nine, ten
// - table add keeps counter bits nine, ten
// - top four address bits from page bits
// - power-down bit: set power-on/clear-op, low-power clears
// - time-out bit: set low-power/clear-op/power-up, watchdog clears
// - reset cause shows in time-out/power-down pair
// - status bit six selects control page
// - bank select: index bits, bank bits
// - page register: page nibble, port five nibble
// - mode bit six enables fast clock
// - mode bit seven: set selects idle, clear selects sleep, which restarts at zero
// - idle wakes on timer, watchdog, port events
// - port nine resets sleep, wakes idle, ignored running
// - display control pair and duty bit
// - wake nibble enables and watchdog enable
// - interrupt flags layout, bit six zero
package morf_pkg;
    typedef enum {ST_RUN, ST_SLEEP, ST_IDLE} morf_state_e;
    // byte addresses on the register bus
    localparam logic [7:0] OFS_INDIRECT = 8'h00;
    localparam logic [7:0] OFS_TIMER = 8'h04;
    localparam logic [7:0] OFS_PC_LOW = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_BANK = 8'h10;
    localparam logic [7:0] OFS_PAGE = 8'h14;
    localparam logic [7:0] OFS_PORT6 = 8'h18;
    localparam logic [7:0] OFS_PORT7 = 8'h1C;
    localparam logic [7:0] OFS_PORT8 = 8'h20;
    localparam logic [7:0] OFS_PORT9 = 8'h24;
    localparam logic [7:0] OFS_MODE = 8'h28;
    localparam logic [7:0] OFS_RSVD = 8'h2C;
    localparam logic [7:0] OFS_RAM_ADDR = 8'h30;
    localparam logic [7:0] OFS_RAM_DATA = 8'h34;
    localparam logic [7:0] OFS_DISP = 8'h38;
    localparam logic [7:0] OFS_INTSTAT = 8'h3C;
    localparam logic [7:0] OFS_TIMER_CTL = 8'h40;
    // core operation codes
    localparam logic [3:0] STEP_OP = 4'h0;
    localparam logic [3:0] DIRECT_JUMP_OP = 4'h1;
    localparam logic [3:0] CALL_OP = 4'h2;
    localparam logic [3:0] SUBROUTINE_RETURN_OP = 4'h3;
    localparam logic [3:0] ACC_MOVE_PC_OP = 4'h4;
    localparam logic [3:0] ACC_ADD_PC_OP = 4'h5;
    localparam logic [3:0] TABLE_OFFSET_ADD = 4'h6;
    localparam logic [3:0] ENTER_LOW_POWER_OP = 4'h7;
    localparam logic [3:0] WATCHDOG_CLEAR_OP = 4'h8;
    // field positions and masks
    localparam int ST_P_BIT = 3;
    localparam int ST_T_BIT = 4;
    localparam int ST_PAGE_BIT = 6;
    localparam logic [7:0] ST_SW_MASK = 8'h47;
    localparam logic [7:0] MODE_SW_MASK = 8'hC0;
    localparam logic [7:0] MODE_FIXED = 8'h10;
    localparam logic [7:0] DISP_SW_MASK = 8'h77;
    localparam logic [7:0] INT_MASK = 8'hBF;
    localparam logic [7:0] PORT6_MASK = 8'h01;
    localparam logic [7:0] RSVD_VALUE = 8'hFF;
    // values after reset
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] ZERO_RST = 8'h00;
    localparam logic [13:0] PC_RST = 14'h0000;
    localparam int STACK_DEPTH = 8;
    localparam int SYNC_W = 13;
endpackage

/* bench/mcu_operational_register_file_tb.sv */
`timescale 1ns/1ns
module mcu_operational_register_file_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic ce = 1'b1;
    logic op_valid = 1'b0;
    logic [3:0] op_code = 4'h0;
    logic [9:0] op_imm = 10'h000;
    logic [7:0] op_acc = 8'h00;
    logic [3:0] ev = 4'h0;
    logic timer_clock_counter = 1'b0;
    logic [3:0] p7 = 4'hf;
    logic [7:0] p9 = 8'hff;
    logic [13:0] pc_addr;
    logic core_restart, core_stopped, io_page, fast_clk_on, watchdog_on;
    logic [2:0] display_mode;
    logic [31:0] q;
    logic e;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 32'h1f87_2819;
    int mdl [0:16];
    int ram [0:255];
    int stk [$];
    int pc, t, p, pg;
    logic [7:0] rw_list [0:12];

    always #4 clk = ~clk;

    morf_regs i_morf_regs (
        .CLK(clk), .RSTN(rstn), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OP_VALID(op_valid), .OP_CODE(op_code),
        .OP_IMM(op_imm), .OP_ACC(op_acc), .WDT_TIMEOUT(ev[0]),
        .EXT_RESET(ev[1]), .CNT1_DONE(ev[2]), .CNT2_DONE(ev[3]),
        .TCC_SLOW_PIN(timer_clock_counter), .P7_INT_PIN(p7), .P9_PIN(p9),
        .PC_ADDR(pc_addr), .CORE_RESTART(core_restart),
        .CORE_STOPPED(core_stopped), .IO_PAGE(io_page),
        .FAST_CLK_ON(fast_clk_on), .WATCHDOG_ON(watchdog_on),
        .DISPLAY_MODE(display_mode)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        err_total++;
        results();
    end

    // ------------------------------------------------------------
    // bus master and reference model
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // data and error are taken at the edge that sees ready
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_total++;
            results();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let that edge's updates settle before anyone compares
        @(negedge clk);
    endtask

    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            morf_pkg::OFS_STATUS: wmask = morf_pkg::ST_SW_MASK;
            morf_pkg::OFS_PORT6: wmask = morf_pkg::PORT6_MASK;
            morf_pkg::OFS_MODE: wmask = morf_pkg::MODE_SW_MASK;
            morf_pkg::OFS_DISP: wmask = morf_pkg::DISP_SW_MASK;
            morf_pkg::OFS_RSVD, morf_pkg::OFS_PC_LOW: wmask = 8'h00;
            default: wmask = 8'hff;
        endcase
    endfunction

    function automatic logic [31:0] rv(input logic [7:0] a);
        case (a)
            morf_pkg::OFS_STATUS: rv = (mdl[3] & 8'h47) | (t << 4) | (p << 3);
            morf_pkg::OFS_INDIRECT: rv = ram[mdl[4]];
            morf_pkg::OFS_RSVD: rv = morf_pkg::RSVD_VALUE;
            morf_pkg::OFS_PC_LOW: rv = pc & 8'hff;
            default: rv = mdl[a >> 2];
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == morf_pkg::OFS_INDIRECT)
            ram[mdl[4]] = d & 8'hff;
        else if (a == morf_pkg::OFS_INTSTAT)
            mdl[15] = mdl[15] & d;
        else
            mdl[a >> 2] = (mdl[a >> 2] & ~wmask(a)) | (d & wmask(a));
        pg = mdl[5] & 4'hf;
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, rv(a));
    endtask

    // one core op; pc model follows the counter-loading rules
    task automatic opx(input int c, input int imm, input int acc);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c[3:0];
        op_imm <= imm[9:0];
        op_acc <= acc[7:0];
        @(posedge clk);
        op_valid <= 1'b0;
        @(negedge clk);
        case (c)
            0: pc = (pc + 1) & 16'h3fff;
            1: pc = (pg << 10) | imm;
            2:
            begin
                stk.push_back((pc + 1) & 16'h3fff);
                pc = (pg << 10) | imm;
            end
            3: pc = stk.pop_back();
            4: pc = (pg << 10) | acc;
            5: pc = (pg << 10) | ((pc + acc) & 8'hff);
            6: pc = (pg << 10) | (pc & 16'h0300) | ((pc + acc) & 8'hff);
            7:
            begin
                t = 1;
                p = 0;
                pc = (pc + 1) & 16'h3fff;
            end
            default:
            begin
                t = 1;
                p = 1;
                pc = (pc + 1) & 16'h3fff;
            end
        endcase
        chk(pc_addr, pc);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        @(negedge clk);
    endtask

    task automatic slow;
        @(posedge clk);
        timer_clock_counter <= 1'b1;
        repeat (6) @(posedge clk);
        timer_clock_counter <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        mdl[1] = (mdl[1] + 1) & 8'hff;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        foreach (mdl[i]) mdl[i] = 0;
        foreach (ram[i]) ram[i] = 0;
        mdl[10] = morf_pkg::MODE_FIXED;
        t = 1;
        p = 1;
        pc = 0;
        pg = 0;
        rw_list = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
                    8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h08};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        chk(pc_addr, 0);
        rd(morf_pkg::OFS_STATUS);
        rd(morf_pkg::OFS_MODE);
        rd(morf_pkg::OFS_INTSTAT);
        // slow source keeps the timer from waking idle on its own
        wr(morf_pkg::OFS_TIMER_CTL, 1);
        foreach (rw_list[i])
        begin
            wr(rw_list[i], $random(seed));
            rd(rw_list[i]);
        end
        chk(io_page, (mdl[3] >> 6) & 1);
        chk(fast_clk_on, (mdl[10] >> 6) & 1);
        chk(watchdog_on, (mdl[14] >> 6) & 1);
        for (int i = 0; i < 8; i++)
        begin
            wr(morf_pkg::OFS_DISP, i);
            chk(display_mode, i);
        end
        apb(1'b0, 8'h44, 32'h0000_0000);
        chk(e, 1);
        chk(q, 0);
        wr(morf_pkg::OFS_BANK, 8'h41);
        wr(morf_pkg::OFS_INDIRECT, 8'h5a);
        wr(morf_pkg::OFS_BANK, 8'hc2);
        wr(morf_pkg::OFS_INDIRECT, 8'ha5);
        wr(morf_pkg::OFS_BANK, 8'h41);
        rd(morf_pkg::OFS_INDIRECT);
        wr(morf_pkg::OFS_TIMER, 8'h10);
        slow();
        slow();
        rd(morf_pkg::OFS_TIMER);
        // a counter pulse while frozen must leave no flag behind
        @(posedge clk);
        ce <= 1'b0;
        pulse(2);
        @(posedge clk);
        ce <= 1'b1;
        rd(morf_pkg::OFS_INTSTAT);
        wr(morf_pkg::OFS_PAGE, 8'h35);
        opx(1, $random(seed) & 10'h3ff, 0);
        opx(0, 0, 0);
        opx(2, 10'h123, 0);
        opx(0, 0, 0);
        opx(3, 0, 0);
        opx(4, 0, $random(seed) & 8'h7f);
        opx(5, 0, 8'h20);
        opx(1, 10'h310, 0);
        opx(6, 0, 8'h05);
        rd(morf_pkg::OFS_PC_LOW);
        opx(8, 0, 0);
        rd(morf_pkg::OFS_STATUS);
        wr(morf_pkg::OFS_MODE, 8'h00);
        opx(7, 0, 0);
        chk(core_stopped, 1);
        rd(morf_pkg::OFS_STATUS);
        pulse(0);
        chk({core_restart, core_stopped, pc_addr}, 16'h8000);
        t = 0;
        pc = 0;
        rd(morf_pkg::OFS_STATUS);
        opx(8, 0, 0);
        pulse(0);
        chk({core_restart, pc_addr}, 15'h4000);
        t = 0;
        pc = 0;
        rd(morf_pkg::OFS_STATUS);
        opx(7, 0, 0);
        pulse(1);
        chk({core_stopped, pc_addr}, 0);
        t = 1;
        pc = 0;
        rd(morf_pkg::OFS_STATUS);
        wr(morf_pkg::OFS_TIMER, 8'hff);
        wr(morf_pkg::OFS_MODE, 8'h80);
        opx(7, 0, 0);
        pulse(0);
        chk({core_stopped, pc_addr}, {1'b0, pc[13:0]});
        opx(7, 0, 0);
        slow();
        chk(core_stopped, 0);
        opx(7, 0, 0);
        @(posedge clk);
        p7 <= 4'h7;
        repeat (8) @(negedge clk);
        chk(core_stopped, 0);
        wr(morf_pkg::OFS_DISP, 8'h10);
        wr(morf_pkg::OFS_MODE, 8'h00);
        opx(7, 0, 0);
        @(posedge clk);
        p9 <= 8'hef;
        repeat (8) @(negedge clk);
        chk(core_stopped, 1);
        @(posedge clk);
        p9 <= 8'hee;
        repeat (8) @(negedge clk);
        chk({core_stopped, pc_addr}, 0);
        @(posedge clk);
        p9 <= 8'hec;
        repeat (8) @(negedge clk);
        chk(pc_addr, 0);
        wr(morf_pkg::OFS_INTSTAT, 0);
        pulse(2);
        pulse(3);
        @(posedge clk);
        p7 <= 4'hf;
        repeat (6) @(posedge clk);
        p7 <= 4'h0;
        wr(morf_pkg::OFS_TIMER, 8'hff);
        slow();
        mdl[15] = morf_pkg::INT_MASK;
        rd(morf_pkg::OFS_INTSTAT);
        wr(morf_pkg::OFS_INTSTAT, 8'h0f);
        rd(morf_pkg::OFS_INTSTAT);
        wr(morf_pkg::OFS_INTSTAT, 0);
        rd(morf_pkg::OFS_INTSTAT);
        results();
    end
endmodule
